// ### hw/wsrc_pkg.sv
/*
  Constants, state codes and register layout for the wake/sleep sample rate control block.
  Assumes a 125 MHz mclk and a host-side serial front end that turns I2C or SPI accesses
  into single-cycle register strobes.
*/
// Behaviour
// - rate register at 0x17: wake code bits 7:4, sleep code bits 3:0, read/write.
// - reset value all zeros with boot pin low, 0xc0 with boot pin high.
// - in low-power and high-performance modes the code selects an output rate.
// - low-power: code 0 is 3200 Hz, halving per step, 0.781 Hz from 12 up.
// - flexible mode: code is decimation; period is (idle+1) ticks times decimation.
// - flexible mode code 6 selects decimation 64.
// - wake power mode 1x makes the upper nibble the wake decimation code.
// - fast settings deliver first sample after 528.5 us plus decimation term.
// - after the first sample, samples follow once per output period.
// - all other settings deliver the first sample within one output period.
// - wake/sleep change inserts a 500 us gap before the new-rate acquisition.
// - boot pin high and data-ready enabled: interrupt line low 5 ms per sample.
// - power mode 00 low-power, 01 high-performance, 1x flexible.
// - high-performance: decimation 2^code, saturating at 4096 from code 12.
// - flexible: decimation 2^code saturating at 4096, each sample 0.3125 ms.
package wsrc_pkg;
  localparam logic [7:0] WSRC_CFG_ADDR = 8'h17;
  localparam logic [7:0] WSRC_CFG_RST_GND = 8'h00;
  localparam logic [7:0] WSRC_CFG_RST_VDD = 8'hc0;
  localparam int WSRC_WAKE_MSB = 7;
  localparam int WSRC_WAKE_LSB = 4;
  localparam int WSRC_SLEEP_MSB = 3;
  localparam int WSRC_SLEEP_LSB = 0;
  localparam logic [1:0] WSRC_PM_LOW = 2'h0;
  localparam logic [1:0] WSRC_PM_HIGH = 2'h1;
  localparam logic [3:0] WSRC_CODE_SAT = 4'hc;
  localparam logic [3:0] WSRC_CODE_FAST = 4'h0;
  localparam logic [1:0] WSRC_LOAD_WAIT = 2'h3;

  // times in nanoseconds; the tick rounds down, the first-sample delay rounds up
  localparam longint WSRC_CLK_NS = 8;
  localparam longint WSRC_TICK_NS = 312500;
  localparam longint WSRC_FIRST_NS = 528500;
  localparam longint WSRC_DEC_STEP_NS = 312000;
  localparam longint WSRC_GAP_NS = 500000;
  localparam longint WSRC_PULSE_NS = 5000000;
  localparam int WSRC_TICK_CYC = int'(WSRC_TICK_NS / WSRC_CLK_NS);
  localparam int WSRC_FIRST_CYC = int'((WSRC_FIRST_NS + WSRC_CLK_NS - 1) / WSRC_CLK_NS);
  localparam int WSRC_DEC_STEP_CYC = int'(WSRC_DEC_STEP_NS / WSRC_CLK_NS);
  localparam int WSRC_GAP_CYC = int'(WSRC_GAP_NS / WSRC_CLK_NS);
  localparam int WSRC_PULSE_CYC = int'(WSRC_PULSE_NS / WSRC_CLK_NS);

  typedef enum logic [3:0] {
    WSRC_PH_STBY = 4'h1,
    WSRC_PH_FIRST = 4'h2,
    WSRC_PH_RUN = 4'h4,
    WSRC_PH_GAP = 4'h8
  } wsrc_phase_t;

  typedef struct packed {
    wsrc_phase_t phase;
    logic [7:0] cfg;
    logic [1:0] ld_cnt;
    logic loaded;
    logic [2:0] pin_sync;
    logic boot;
    logic wake_cur;
    logic [27:0] wait_cnt;
    logic [15:0] div_cnt;
    logic [24:0] per;
    logic [24:0] per_cnt;
    logic [19:0] pulse_cnt;
    logic sample;
    logic [3:0] dec_log2;
    logic [7:0] rdata;
  } wsrc_st_t;
endpackage : wsrc_pkg

// ### hw/wsrc_rate_ctrl.sv
/*
  Wake/sleep sample rate control: rate register, first-sample delay, steady sample
  strobes, state-change gap and the motion-mode data-ready pulse.
  Assumes active, wake state, power modes and idle times come from logic on mclk;
  only the boot-mode pin is asynchronous.
*/
`timescale 1ns/1ps
module wsrc_rate_ctrl
  import wsrc_pkg::*;
#(
  parameter int TICK_CYC = WSRC_TICK_CYC,
  parameter int FIRST_CYC = WSRC_FIRST_CYC,
  parameter int DEC_STEP_CYC = WSRC_DEC_STEP_CYC,
  parameter int GAP_CYC = WSRC_GAP_CYC,
  parameter int PULSE_CYC = WSRC_PULSE_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic boot_mode_pin,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic active,
  input wire logic wake_state,
  input wire logic [1:0] wake_power_mode,
  input wire logic [1:0] sleep_power_mode,
  input wire logic [11:0] wake_idle,
  input wire logic [11:0] sleep_idle,
  input wire logic data_ready_interrupt,
  output logic sample_strobe,
  output logic [3:0] decimation_log2,
  output logic gap_active,
  output logic first_interrupt_line_n
);
  wsrc_st_t q;
  wsrc_st_t d;
  logic wr_hit;
  logic [3:0] code;
  logic [1:0] pm;
  logic [11:0] idle;
  logic flex;
  logic [3:0] n_sat;
  logic [24:0] per_new;
  logic [3:0] dec_new;
  logic fast;
  logic [27:0] first_wait;
  logic tick;
  logic leave_state;

  assign wr_hit = reg_wr && (reg_addr == WSRC_CFG_ADDR);

  // selection of the settings for the state that is about to run
  always_comb begin
    code = wake_state ? q.cfg[WSRC_WAKE_MSB:WSRC_WAKE_LSB] : q.cfg[WSRC_SLEEP_MSB:WSRC_SLEEP_LSB];
    pm = wake_state ? wake_power_mode : sleep_power_mode;
    idle = wake_state ? wake_idle : sleep_idle;
    flex = pm[1];
    n_sat = (code >= WSRC_CODE_SAT) ? WSRC_CODE_SAT : code;
    if (flex) begin
      per_new = 25'({1'b0, idle} + 13'h001) << n_sat;
    end else begin
      per_new = 25'h0000001 << n_sat;
    end
    dec_new = (flex || pm == WSRC_PM_HIGH) ? n_sat : 4'h0;
    fast = flex ? (idle == 12'h000) : (code == WSRC_CODE_FAST);
    first_wait = 28'(FIRST_CYC) + ((28'(DEC_STEP_CYC) << dec_new) - 28'(DEC_STEP_CYC));
  end

  assign tick = (q.div_cnt == 16'(TICK_CYC - 1));
  assign leave_state = (wake_state != q.wake_cur) && (q.phase != WSRC_PH_GAP);

  always_comb begin
    d = q;
    d.sample = 1'b0;
    // three-stage pin synchroniser; the value moves once the last two agree
    d.pin_sync = {q.pin_sync[1:0], boot_mode_pin};
    if (q.pin_sync[1] == q.pin_sync[2]) begin
      d.boot = q.pin_sync[2];
    end
    // reset value waits for a settled pin, so the async reset stays constant
    if (!q.loaded) begin
      if (q.ld_cnt == WSRC_LOAD_WAIT) begin
        d.loaded = 1'b1;
        d.cfg = d.boot ? WSRC_CFG_RST_VDD : WSRC_CFG_RST_GND;
      end else begin
        d.ld_cnt = q.ld_cnt + 2'h1;
      end
    end
    if (wr_hit) begin
      d.cfg = reg_wdata;
      d.loaded = 1'b1;
    end
    d.rdata = (reg_addr == WSRC_CFG_ADDR) ? q.cfg : 8'h00;
    if (!active) begin
      d.phase = WSRC_PH_STBY;
    end else if (q.phase != WSRC_PH_STBY && leave_state) begin
      d.phase = WSRC_PH_GAP;
      d.wait_cnt = 28'(GAP_CYC);
      d.wake_cur = wake_state;
      d.per = per_new;
      d.dec_log2 = dec_new;
    end else begin
      unique case (q.phase)
        WSRC_PH_STBY: begin
          d.per = per_new;
          d.dec_log2 = dec_new;
          d.wake_cur = wake_state;
          d.div_cnt = 16'h0000;
          d.per_cnt = 25'h0000000;
          if (fast) begin
            d.phase = WSRC_PH_FIRST;
            d.wait_cnt = first_wait;
          end else begin
            d.phase = WSRC_PH_RUN;
          end
        end
        WSRC_PH_FIRST, WSRC_PH_GAP: begin
          if (q.wait_cnt <= 28'h0000001) begin
            d.sample = 1'b1;
            d.phase = WSRC_PH_RUN;
            d.div_cnt = 16'h0000;
            d.per_cnt = 25'h0000000;
          end else begin
            d.wait_cnt = q.wait_cnt - 28'h0000001;
          end
        end
        WSRC_PH_RUN: begin
          if (tick) begin
            d.div_cnt = 16'h0000;
            if (q.per_cnt >= q.per - 25'h0000001) begin
              d.per_cnt = 25'h0000000;
              d.sample = 1'b1;
            end else begin
              d.per_cnt = q.per_cnt + 25'h0000001;
            end
          end else begin
            d.div_cnt = q.div_cnt + 16'h0001;
          end
        end
      endcase
    end
    // restarting on every sample means fast rates hold the line low throughout
    if (d.sample && q.boot && data_ready_interrupt) begin
      d.pulse_cnt = 20'(PULSE_CYC);
    end else if (q.pulse_cnt != 20'h00000) begin
      d.pulse_cnt = q.pulse_cnt - 20'h00001;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '{phase: WSRC_PH_STBY, default: '0};
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign sample_strobe = q.sample;
  assign decimation_log2 = q.dec_log2;
  assign gap_active = (q.phase == WSRC_PH_GAP);
  assign first_interrupt_line_n = (q.pulse_cnt == 20'h00000);

  sequence s_start;
    clk_en && q.phase == WSRC_PH_STBY && active;
  endsequence

  sequence s_hold_run;
    clk_en && active && !leave_state;
  endsequence

  property p_write;
    @(posedge mclk) disable iff (rst) clk_en && wr_hit |=> q.cfg == $past(reg_wdata);
  endproperty
  a_write: assert property (p_write) else $error("rate register write lost");

  property p_boot_load;
    @(posedge mclk) disable iff (rst)
      clk_en && !q.loaded && q.ld_cnt == WSRC_LOAD_WAIT && !wr_hit
      |=> q.cfg == (q.boot ? WSRC_CFG_RST_VDD : WSRC_CFG_RST_GND);
  endproperty
  a_boot_load: assert property (p_boot_load) else $error("wrong boot reset value");

  property p_lpm_sat;
    @(posedge mclk) disable iff (rst)
      s_start and (pm == WSRC_PM_LOW && code >= WSRC_CODE_SAT)
      |=> q.per == 25'h0001000 && q.dec_log2 == 4'h0;
  endproperty
  a_lpm_sat: assert property (p_lpm_sat) else $error("low-power saturation wrong");

  property p_flex64;
    @(posedge mclk) disable iff (rst)
      s_start and (flex && code == 4'h6)
      |=> q.dec_log2 == 4'h6 && q.per == ($past(25'({1'b0, idle} + 13'h001)) << 6);
  endproperty
  a_flex64: assert property (p_flex64) else $error("flexible decimation 64 wrong");

  property p_first;
    @(posedge mclk) disable iff (rst)
      s_start and fast |=> q.phase == WSRC_PH_FIRST && q.wait_cnt == $past(first_wait);
  endproperty
  a_first: assert property (p_first) else $error("first-sample delay not loaded");

  property p_period;
    @(posedge mclk) disable iff (rst)
      s_hold_run and (q.phase == WSRC_PH_RUN && tick && q.per_cnt == q.per - 25'h0000001)
      |=> sample_strobe && q.per_cnt == 25'h0000000;
  endproperty
  a_period: assert property (p_period) else $error("periodic sample missed");

  property p_slow_start;
    @(posedge mclk) disable iff (rst)
      s_start and !fast |=> q.phase == WSRC_PH_RUN && q.per_cnt == 25'h0000000 && !sample_strobe;
  endproperty
  a_slow_start: assert property (p_slow_start) else $error("slow start wrong");

  property p_gap;
    @(posedge mclk) disable iff (rst)
      clk_en && active && q.phase != WSRC_PH_STBY && leave_state
      |=> gap_active && q.wait_cnt == 28'(GAP_CYC) && !sample_strobe;
  endproperty
  a_gap: assert property (p_gap) else $error("state change gap missing");

  property p_pulse;
    @(posedge mclk) disable iff (rst)
      clk_en && d.sample && q.boot && data_ready_interrupt
      |=> !first_interrupt_line_n && q.pulse_cnt == 20'(PULSE_CYC);
  endproperty
  a_pulse: assert property (p_pulse) else $error("data-ready pulse missing");
endmodule : wsrc_rate_ctrl

// ### testbench/wsrc_host_model.sv
/*
  Host side model: byte writes and reads of the rate register.
  Assumes the block samples register strobes on rising mclk.
*/
`timescale 1ns/1ps
module wsrc_host_model
  import wsrc_pkg::*;
(
  input wire logic mclk,
  input wire logic active,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end

  // rate changes wait for standby; the block does not guard against them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    while (active) @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    @(negedge mclk);
    d = reg_rdata;
  endtask : rd
endmodule : wsrc_host_model

// ### testbench/tb.sv
/*
  Self-checking bench for the wake/sleep sample rate block.
  Assumes shortened timing parameters and the host model for register access.
*/
`timescale 1ns/1ps
module tb;
  import wsrc_pkg::*;
  localparam int TK = 4;
  localparam int FC = 7;
  localparam int DS = 3;
  localparam int GC = 5;
  localparam int PC = 6;
  logic mclk, rst, clk_en, boot_mode_pin, reg_wr, active, wake_state;
  logic data_ready_interrupt, sample_strobe, gap_active, first_interrupt_line_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v, e;
  logic [1:0] wake_power_mode, sleep_power_mode, pm;
  logic [11:0] wake_idle, sleep_idle, idl;
  logic [3:0] decimation_log2, c;
  int failures, tests_run, seed, n;

  wsrc_rate_ctrl #(.TICK_CYC(TK), .FIRST_CYC(FC), .DEC_STEP_CYC(DS), .GAP_CYC(GC),
    .PULSE_CYC(PC)) u_wsrc_rate_ctrl (.mclk(mclk), .rst(rst), .clk_en(clk_en),
    .boot_mode_pin(boot_mode_pin), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .active(active),
    .wake_state(wake_state), .wake_power_mode(wake_power_mode),
    .sleep_power_mode(sleep_power_mode), .wake_idle(wake_idle), .sleep_idle(sleep_idle),
    .data_ready_interrupt(data_ready_interrupt), .sample_strobe(sample_strobe),
    .decimation_log2(decimation_log2), .gap_active(gap_active),
    .first_interrupt_line_n(first_interrupt_line_n));
  wsrc_host_model u_wsrc_host_model (.mclk(mclk), .active(active), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic results;
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      failures++;
      $display("unexpected %s expected %0h seen %0h", nm, x, s);
    end
  endtask : check

  function automatic int per_cyc(logic [1:0] m, logic [3:0] k, logic [11:0] t);
    int p;
    p = 1 << ((k > 12) ? 12 : k);
    if (m[1]) p = p * (t + 1);
    return p * TK;
  endfunction : per_cyc

  function automatic int first_cyc(logic [1:0] m, logic [3:0] k, logic [11:0] t);
    int d;
    d = (m == 2'h0) ? 0 : ((k > 12) ? 12 : k);
    // one edge to leave standby, then the countdown; strobe is seen at the next falling edge
    if (m[1] ? (t == 0) : (k == 0)) return FC + ((1 << d) - 1) * DS + 1;
    return per_cyc(m, k, t) + 1;
  endfunction : first_cyc

  task automatic wait_strobe(output int k);
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (sample_strobe !== 1'b1 && k < 70000);
  endtask : wait_strobe

  task automatic run(input logic [1:0] m, input logic [3:0] k, input logic [11:0] t);
    int q;
    u_wsrc_host_model.wr(WSRC_CFG_ADDR, {k, k});
    @(negedge mclk);
    wake_power_mode = m;
    sleep_power_mode = m;
    wake_idle = t;
    sleep_idle = t;
    active = 1'b1;
    wait_strobe(q);
    check("first", q, first_cyc(m, k, t));
    check("dec", decimation_log2, (m == 2'h0) ? 0 : ((k > 12) ? 12 : k));
    wait_strobe(q);
    check("period", q, per_cyc(m, k, t));
    active = 1'b0;
  endtask : run

  // longest scenario is the saturated high-performance run, about 33k cycles
  initial begin
    #560000;
    failures++;
    results();
  end

  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    boot_mode_pin = 1'b0;
    active = 1'b0;
    wake_state = 1'b1;
    wake_power_mode = 2'h0;
    sleep_power_mode = 2'h0;
    wake_idle = 12'h000;
    sleep_idle = 12'h000;
    data_ready_interrupt = 1'b0;
    seed = 32'hdc140c95;
    failures = 0;
    tests_run = 0;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    repeat (6) @(negedge mclk);
    u_wsrc_host_model.rd(WSRC_CFG_ADDR, v);
    check("reset_lo", v, WSRC_CFG_RST_GND);
    for (int i = 0; i < 3; i++) begin
      e = 8'($random(seed));
      u_wsrc_host_model.wr(WSRC_CFG_ADDR, e);
      u_wsrc_host_model.rd(WSRC_CFG_ADDR, v);
      check("cfg", v, e);
    end
    u_wsrc_host_model.wr(8'h18, ~e);
    u_wsrc_host_model.rd(8'h18, v);
    check("unmapped", v, 8'h00);
    clk_en = 1'b0;
    u_wsrc_host_model.wr(WSRC_CFG_ADDR, ~e);
    clk_en = 1'b1;
    u_wsrc_host_model.rd(WSRC_CFG_ADDR, v);
    check("frozen", v, e);
    for (int i = 0; i < 6; i++) run(2'h0, 4'(i), 12'h000);
    run(2'h1, 4'h0, 12'h000);
    run(2'h1, 4'hd, 12'h000);
    run(2'h2, 4'h6, 12'h000);
    run(2'h3, 4'h1, 12'h002);
    for (int i = 0; i < 4; i++) begin
      pm = 2'($random(seed));
      c = 4'($unsigned($random(seed)) % 7);
      idl = 12'($unsigned($random(seed)) % 4);
      run(pm, c, idl);
    end
    boot_mode_pin = 1'b1;
    repeat (4) @(negedge mclk);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    repeat (6) @(negedge mclk);
    u_wsrc_host_model.rd(WSRC_CFG_ADDR, v);
    check("reset_hi", v, WSRC_CFG_RST_VDD);
    // motion mode keeps low-power at or below 100 Hz; nibbles differ to tell the states apart
    u_wsrc_host_model.wr(WSRC_CFG_ADDR, 8'h56);
    @(negedge mclk);
    wake_power_mode = 2'h0;
    sleep_power_mode = 2'h0;
    data_ready_interrupt = 1'b1;
    active = 1'b1;
    wait_strobe(n);
    check("irq_low", first_interrupt_line_n, 1'b0);
    repeat (PC) @(negedge mclk);
    check("irq_high", first_interrupt_line_n, 1'b1);
    wake_state = 1'b0;
    @(negedge mclk);
    check("gap", gap_active, 1'b1);
    wait_strobe(n);
    check("gap_len", n, GC);
    wait_strobe(n);
    check("sleep_period", n, per_cyc(2'h0, 4'h6, 12'h000));
    active = 1'b0;
    results();
  end
endmodule : tb
